// *** hdl/backup_charger_boost_control.sv ***
// Purpose: enable interlocks, charger state machine, status and apb registers
// Assumes: sense inputs are synchronous to mclk; settings are retained in all modes
// Notes: alert_out_n uses a separate output enable, low while driving
`timescale 1ns/1ps
module backup_charger_boost_control #(
    parameter int unsigned PULSE_CYCLES  = chg_pkg::PULSE_CYC,
    parameter int unsigned SETTLE_CYCLES = chg_pkg::SETTLE_CYC
) (
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire chg_pkg::sense_s sense,
    input  wire logic            charger_inhibit_pin,
    output chg_pkg::drive_s      drive,
    output logic                 backup_start_pulse,
    output logic                 alert_out_n,
    output logic                 alert_oe_n,
    output logic [4:0]           charge_current_setting,
    output logic [4:0]           cv_threshold_setting
);

    // ************************************************************
    // register bus
    // ************************************************************
    logic [7:0]          ctrl_r;
    logic [7:0]          mask_r;
    logic [7:0]          general_status_reg;
    logic [7:0]          chg_status;
    logic                cv_alert_r;
    logic                done_alert_r;
    logic                sup_alert_r;
    logic                tsd_alert_r;
    logic                clr_req;
    logic [7:0]          clr_bits;
    chg_pkg::chg_state_e state_r;
    chg_pkg::chg_state_e state_nxt;
    logic [31:0]         settle_cnt_r;
    logic [31:0]         pulse_cnt_r;
    logic                boost_reg_d_r;
    logic                access;
    logic                supply_ok;

    assign access   = psel && penable && !pready;
    assign clr_req  = access && pwrite && (paddr == chg_pkg::ADDR_GEN_STAT);
    assign clr_bits = pwdata[7:0];

    // single wait state: pready pulses one cycle into the access phase
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (access) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    chg_pkg::ADDR_CTRL:     prdata <= {24'h000000, ctrl_r};
                    chg_pkg::ADDR_CC:       prdata <= {27'h0000000, charge_current_setting};
                    chg_pkg::ADDR_CV:       prdata <= {27'h0000000, cv_threshold_setting};
                    chg_pkg::ADDR_CHG_STAT: prdata <= {24'h000000, chg_status};
                    chg_pkg::ADDR_GEN_STAT: prdata <= {24'h000000, general_status_reg};
                    chg_pkg::ADDR_MASK:     prdata <= {24'h000000, mask_r};
                    default:                pslverr <= 1'b1;
                endcase
            end else if (!(paddr inside {chg_pkg::ADDR_CTRL, chg_pkg::ADDR_CC, chg_pkg::ADDR_CV,
                                         chg_pkg::ADDR_GEN_STAT, chg_pkg::ADDR_MASK})) begin
                pslverr <= 1'b1;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // configuration registers; only reset clears them, boost standby never does
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r                 <= chg_pkg::CTRL_RST;
            mask_r                 <= chg_pkg::MASK_RST;
            charge_current_setting <= chg_pkg::SETTING_RST;
            cv_threshold_setting   <= chg_pkg::SETTING_RST;
        end else if (access && pwrite) begin
            if (paddr == chg_pkg::ADDR_CTRL) ctrl_r <= pwdata[7:0];
            if (paddr == chg_pkg::ADDR_MASK) mask_r <= pwdata[7:0];
            if (paddr == chg_pkg::ADDR_CC)   charge_current_setting <= pwdata[4:0];
            if (paddr == chg_pkg::ADDR_CV)   cv_threshold_setting <= pwdata[4:0];
        end
    end

    // ************************************************************
    // enable interlocks
    // ************************************************************
    logic boost_go;
    logic charger_go;
    logic health_go;

    // bias lockout gates every function; boost regulation takes priority over charging
    assign boost_go   = sense.bias_ready && ctrl_r[chg_pkg::CTRL_BST_EN]
                        && sense.boost_rail_below_wake && !sense.thermal_shutdown_flag;
    assign charger_go = sense.bias_ready && ctrl_r[chg_pkg::CTRL_CHARGER_ENABLE_BIT] && !charger_inhibit_pin
                        && !boost_go && !sense.thermal_shutdown_flag;
    assign health_go  = sense.bias_ready && ctrl_r[chg_pkg::CTRL_HC_EN]
                        && !boost_go && !sense.thermal_shutdown_flag;
    assign supply_ok  = !sense.supply_low && !sense.supply_ovp && !sense.supply_below_cell;

    // ************************************************************
    // charger state machine
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        if (!charger_go) begin
            state_nxt = chg_pkg::CHG_OFF;
        end else begin
            unique case (state_r)
                chg_pkg::CHG_OFF:     state_nxt = chg_pkg::CHG_STANDBY;
                chg_pkg::CHG_STANDBY: if (settle_cnt_r == 32'h0000_0000 && supply_ok)
                                          state_nxt = chg_pkg::CHG_PRECHG;
                chg_pkg::CHG_PRECHG:  if (!supply_ok) state_nxt = chg_pkg::CHG_STANDBY;
                                      else if (sense.cell_above_precharge)
                                          state_nxt = chg_pkg::CHG_CC;
                chg_pkg::CHG_CC:      if (!supply_ok) state_nxt = chg_pkg::CHG_STANDBY;
                                      else if (sense.cell_above_cv)
                                          state_nxt = chg_pkg::CHG_CV;
                chg_pkg::CHG_CV:      if (!supply_ok) state_nxt = chg_pkg::CHG_STANDBY;
                                      else if (!sense.cell_above_cv)
                                          state_nxt = chg_pkg::CHG_CC;
                                      else if (sense.current_below_term)
                                          state_nxt = chg_pkg::CHG_DONE;
                chg_pkg::CHG_DONE:    if (!supply_ok) state_nxt = chg_pkg::CHG_STANDBY;
                                      else if (sense.cell_below_recharge)
                                          state_nxt = chg_pkg::CHG_CC;
                default:              state_nxt = chg_pkg::CHG_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) state_r <= chg_pkg::CHG_OFF;
        else        state_r <= state_nxt;
    end

    // settling timer loads on entry to standby from off, counts down to zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt_r <= 32'h0000_0000;
        end else if (state_r == chg_pkg::CHG_OFF && state_nxt == chg_pkg::CHG_STANDBY) begin
            settle_cnt_r <= 32'(SETTLE_CYCLES - 1);
        end else if (state_r == chg_pkg::CHG_STANDBY && settle_cnt_r != 32'h0000_0000) begin
            settle_cnt_r <= settle_cnt_r - 32'h0000_0001;
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    // sticky alerts: a new event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cv_alert_r   <= 1'b0;
            done_alert_r <= 1'b0;
            sup_alert_r  <= 1'b0;
            tsd_alert_r  <= 1'b0;
        end else begin
            if (state_nxt == chg_pkg::CHG_CV || state_nxt == chg_pkg::CHG_DONE)
                cv_alert_r <= 1'b1;
            else if (clr_req && clr_bits[chg_pkg::GS_CV])
                cv_alert_r <= 1'b0;
            if (state_nxt == chg_pkg::CHG_DONE)
                done_alert_r <= 1'b1;
            else if (clr_req && clr_bits[chg_pkg::GS_DONE])
                done_alert_r <= 1'b0;
            if (charger_go && !supply_ok)
                sup_alert_r <= 1'b1;
            else if (clr_req && clr_bits[chg_pkg::GS_SUP])
                sup_alert_r <= 1'b0;
            if (sense.thermal_shutdown_flag)
                tsd_alert_r <= 1'b1;
            else if (clr_req && clr_bits[chg_pkg::GS_TSD])
                tsd_alert_r <= 1'b0;
        end
    end

    // supply low forced while charger is disabled: its sensing is powered down
    assign chg_status = {ctrl_r[chg_pkg::CTRL_CHARGER_ENABLE_BIT], state_r,
                         1'b0,
                         sense.supply_low || !ctrl_r[chg_pkg::CTRL_CHARGER_ENABLE_BIT],
                         sense.supply_ovp, sense.supply_below_cell};
    assign general_status_reg = {boost_go, 1'b0, cv_alert_r, done_alert_r, sup_alert_r,
                         1'b0, tsd_alert_r, 1'b0};

    // ************************************************************
    // outputs
    // ************************************************************
    // one-shot: armed only by a rising edge of regulation
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            boost_reg_d_r      <= 1'b0;
            pulse_cnt_r        <= 32'h0000_0000;
            backup_start_pulse <= 1'b0;
        end else begin
            boost_reg_d_r <= boost_go;
            if (boost_go && !boost_reg_d_r) begin
                pulse_cnt_r        <= 32'(PULSE_CYCLES - 1);
                backup_start_pulse <= 1'b1;
            end else if (pulse_cnt_r != 32'h0000_0000) begin
                pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
            end else begin
                backup_start_pulse <= 1'b0;
            end
        end
    end

    // open-drain alert: reset mask selects boost only
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alert_out_n <= 1'b1;
            alert_oe_n  <= 1'b1;
            drive       <= '0;
        end else begin
            alert_out_n <= ~|(general_status_reg & mask_r);
            alert_oe_n  <= ~|(general_status_reg & mask_r);
            drive.boost_regulate      <= boost_go;
            drive.charger_on          <= state_nxt inside {chg_pkg::CHG_PRECHG, chg_pkg::CHG_CC,
                                                           chg_pkg::CHG_CV};
            drive.precharge_limit     <= state_nxt == chg_pkg::CHG_PRECHG;
            drive.health_check_on     <= health_go;
            drive.load_disconnect_fet <= boost_go;
        end
    end

endmodule : backup_charger_boost_control

// *** hdl/chg_pkg.sv ***
// Purpose: constants and types for the backup charger and boost control block
// Assumes: analog comparators arrive as clean levels synchronous to mclk
// Notes: register offsets are byte addresses on a 32-bit apb bus
// Contract
// - health check needs bit, no boost, no shutdown
// - boost needs bit, rail low, no shutdown
// - regulating boost disables health check and charger
// - charger needs bit, inhibit low, no boost
// - bias lockout inhibits boost, charging, health check
// - off until enabled; then standby with timer
// - standby until timer done and supplies valid
// - precharge at small current until threshold
// - cc at setting; cv above threshold
// - cv to done when current below termination
// - done exits to off, standby or cc
// - cv state raises cv alert flag
// - done sets done alert, keeps cv alert
// - live state, supply flags and alert readable
// - charger disabled reports supply low as one
// - inhibit pin high resets charger machine
// - backup start pulse on regulation start
// - no retrigger until regulation left
// - alert low on boost by default, maskable
// - configuration retained in boost standby
// - load fet off until wake threshold trips
package chg_pkg;

    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SETTLE_NS     = 15_000;
    localparam int unsigned SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PULSE_MS      = 200;
    localparam int unsigned PULSE_CYC     = PULSE_MS * (CLK_HZ / 1000);

    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_CC        = 8'h04;
    localparam logic [7:0] ADDR_CV        = 8'h08;
    localparam logic [7:0] ADDR_CHG_STAT  = 8'h0C;
    localparam logic [7:0] ADDR_GEN_STAT  = 8'h10;
    localparam logic [7:0] ADDR_MASK      = 8'h14;

    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [4:0] SETTING_RST    = 5'h00;
    localparam logic [7:0] MASK_RST       = 8'h80;

    // control bit positions
    localparam int unsigned CTRL_HC_EN    = 7;
    localparam int unsigned CTRL_CHARGER_ENABLE_BIT   = 3;
    localparam int unsigned CTRL_BST_EN   = 1;

    // general status bit positions (mask uses the same layout)
    localparam int unsigned GS_BOOST      = 7;
    localparam int unsigned GS_CV         = 5;
    localparam int unsigned GS_DONE       = 4;
    localparam int unsigned GS_SUP        = 3;
    localparam int unsigned GS_TSD        = 1;

    typedef enum logic [2:0] {
        CHG_OFF     = 3'b000,
        CHG_STANDBY = 3'b001,
        CHG_PRECHG  = 3'b010,
        CHG_CC      = 3'b011,
        CHG_CV      = 3'b100,
        CHG_DONE    = 3'b101
    } chg_state_e;

    // analog comparator results
    typedef struct packed {
        logic bias_ready;
        logic thermal_shutdown_flag;
        logic boost_rail_below_wake;
        logic supply_low;
        logic supply_ovp;
        logic supply_below_cell;
        logic cell_above_precharge;
        logic cell_above_cv;
        logic cell_below_recharge;
        logic current_below_term;
    } sense_s;

    // enables toward the analog blocks
    typedef struct packed {
        logic boost_regulate;
        logic charger_on;
        logic health_check_on;
        logic precharge_limit;
        logic load_disconnect_fet;
    } drive_s;

endpackage : chg_pkg

// *** verification/cell_env_model.sv ***
// Purpose: behavioural stand-in for the analog side: cell, rails and bias
// Assumes: cell level climbs one step per cycle while the charger drives it
// Notes: only the supply-low comparator can be faulted; ovp and below-cell stay clear
`timescale 1ns/1ps
module cell_env_model (
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            bias_ok,
    input  wire logic            hot,
    input  wire logic            rail_low,
    input  wire logic            drain,
    input  wire logic            sup_bad,
    input  wire chg_pkg::drive_s drive,
    output chg_pkg::sense_s      sense
);
    logic [4:0] lvl_r;

    // cell level; drain pins it below the recharge point so the charger must react
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            lvl_r <= 5'h00;
        else if (drain)
            lvl_r <= 5'h0A;
        else if (drive.charger_on && lvl_r < 5'h14)
            lvl_r <= lvl_r + 5'h01;
    end

    // comparator outputs in struct order
    assign sense = {bias_ok, hot, rail_low, sup_bad, 2'b00, lvl_r >= 5'h08, lvl_r >= 5'h10, lvl_r < 5'h0C,
                    lvl_r >= 5'h14};
endmodule : cell_env_model

// *** verification/chg_properties.sv ***
// Purpose: interlock, pulse and bus timing checks on the top ports
// Assumes: drive outputs register one edge after their causes
// Notes: bound into backup_charger_boost_control
`timescale 1ns/1ps
module chg_properties #(
    parameter int unsigned PULSE_CYCLES  = 50,
    parameter int unsigned SETTLE_CYCLES = 4
) (
    input wire logic            mclk,
    input wire logic            rst_b,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire chg_pkg::sense_s sense,
    input wire logic            charger_inhibit_pin,
    input wire chg_pkg::drive_s drive,
    input wire logic            backup_start_pulse,
    input wire logic            alert_out_n,
    input wire logic            alert_oe_n
);
    // ****************
    // checks
    // ****************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [31:0] hi_cnt_r;

    // length of the current backup pulse, counted in helper logic
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            hi_cnt_r <= 32'h0;
        else
            hi_cnt_r <= backup_start_pulse ? hi_cnt_r + 32'h1 : 32'h0;
    end

    property p_hc_gate; drive.health_check_on |-> $past(sense.bias_ready && !sense.thermal_shutdown_flag); endproperty
    a_hc_gate: assert property (p_hc_gate) else $error("health check on while blocked");
    property p_bst_gate;
        drive.boost_regulate |-> $past(sense.boost_rail_below_wake && !sense.thermal_shutdown_flag);
    endproperty
    a_bst_gate: assert property (p_bst_gate) else $error("boost on while blocked");
    property p_excl; drive.boost_regulate |-> !drive.charger_on && !drive.health_check_on; endproperty
    a_excl: assert property (p_excl) else $error("charger or check on during boost");
    property p_chg_gate;
        drive.charger_on |-> $past(!charger_inhibit_pin && sense.bias_ready && !sense.thermal_shutdown_flag);
    endproperty
    a_chg_gate: assert property (p_chg_gate) else $error("charger on while blocked");
    property p_bias; !sense.bias_ready |=> drive[4:2] == 3'b000; endproperty
    a_bias: assert property (p_bias) else $error("function on without bias");
    property p_plen; $fell(backup_start_pulse) |-> hi_cnt_r == PULSE_CYCLES; endproperty
    a_plen: assert property (p_plen) else $error("backup pulse wrong length");
    property p_alert; alert_out_n == alert_oe_n; endproperty
    a_alert: assert property (p_alert) else $error("alert level and enable disagree");
    property p_fet; drive.boost_regulate |-> drive.load_disconnect_fet; endproperty
    a_fet: assert property (p_fet) else $error("load fet off during boost");
    property p_fet_off; !$past(sense.boost_rail_below_wake) |-> !drive.load_disconnect_fet; endproperty
    a_fet_off: assert property (p_fet_off) else $error("load fet on before wake threshold");
    property p_prechg; drive.precharge_limit |-> drive.charger_on; endproperty
    a_prechg: assert property (p_prechg) else $error("precharge limit without charging");
    property p_rdy; pready |-> $past(psel && penable) ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not a single answer pulse");

    cover property ($fell(backup_start_pulse));
    cover property (drive.charger_on);
    cover property (pready && pslverr);
endmodule : chg_properties

bind backup_charger_boost_control chg_properties #(
    .PULSE_CYCLES (PULSE_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) chg_properties_i (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .sense(sense), .charger_inhibit_pin(charger_inhibit_pin), .drive(drive),
    .backup_start_pulse(backup_start_pulse), .alert_out_n(alert_out_n), .alert_oe_n(alert_oe_n)
);

// *** verification/backup_charger_boost_control_tb_top.sv ***
// Purpose: self-checking bench for the charger and boost control block
// Assumes: pulse shortened to 50 cycles, settle timer to 4
// Notes: registers are reached only through apb
`timescale 1ns/1ps
module backup_charger_boost_control_tb_top;
    localparam int unsigned PULSE_T = 50;
    // low-current ramp: codes are arbitrary stand-ins, hold scaled down like the pulse
    localparam logic [4:0]  CC_HIGH = 5'h02;
    localparam logic [4:0]  CC_LOW  = 5'h00;
    localparam int unsigned HOLD_T  = 100;
    logic            mclk, rst_b, psel, penable, pwrite, pready, pslverr, inhibit, pulse;
    logic            alert_out_n, alert_oe_n, bias_ok, hot, rail_low, drain, rerr, sup_bad;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rdat, v;
    logic [4:0]      cc_set, cv_set;
    chg_pkg::sense_s sense;
    chg_pkg::drive_s drive;
    int              err_count, compares, cyc, n;

    backup_charger_boost_control #(.PULSE_CYCLES(PULSE_T), .SETTLE_CYCLES(4)) backup_charger_boost_control_i (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
        .charger_inhibit_pin(inhibit), .drive(drive), .backup_start_pulse(pulse), .alert_out_n(alert_out_n),
        .alert_oe_n(alert_oe_n), .charge_current_setting(cc_set), .cv_threshold_setting(cv_set));
    cell_env_model cell_env_model_i (.mclk(mclk), .rst_b(rst_b), .bias_ok(bias_ok), .hot(hot),
        .rail_low(rail_low), .drain(drain), .sup_bad(sup_bad), .drive(drive), .sense(sense));

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // a hang ends the run with a counted mismatch
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            finish_test();
        end
    end

    function automatic logic [31:0] stat_exp(input logic en, input logic [2:0] st);
        return {24'h0, en, st, 1'b0, !en, 2'b00};
    endfunction : stat_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // poll the live state field; bounded
    task automatic wait_state(input logic [2:0] s);
        n = 0;
        do begin
            apb(1'b0, chg_pkg::ADDR_CHG_STAT, 32'h0);
            n++;
        end while (rdat[6:4] !== s && n < 100);
        chk(32'(rdat[6:4]), 32'(s));
    endtask : wait_state

    // pulse length, then silence while boost keeps running
    task automatic pulse_chk();
        n = 0;
        while (pulse !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        while (pulse === 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk(32'(n), 32'(PULSE_T));
        repeat (60) @(posedge mclk);
        chk(32'(pulse), 32'h0);
    endtask : pulse_chk

    task automatic finish_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    initial begin
        {mclk, rst_b, psel, penable, pwrite, inhibit, hot, rail_low, drain, sup_bad} = '0;
        {paddr, pwdata, err_count, compares, cyc} = '0;
        bias_ok = 1'b1;
        void'($urandom(32'h0276));
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, chg_pkg::ADDR_CTRL, 32'h0);
        chk(rdat, 32'(chg_pkg::CTRL_RST));
        apb(1'b0, chg_pkg::ADDR_MASK, 32'h0);
        chk(rdat, 32'(chg_pkg::MASK_RST));
        apb(1'b0, 8'h40, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        apb(1'b1, chg_pkg::ADDR_CHG_STAT, 32'hFF);
        chk(32'(rerr), 32'h1);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            apb(1'b1, chg_pkg::ADDR_CC, {27'h0, v[4:0]});
            apb(1'b1, chg_pkg::ADDR_CV, {27'h0, v[9:5]});
            apb(1'b0, chg_pkg::ADDR_CC, 32'h0);
            chk(rdat, {27'h0, v[4:0]});
            chk({cc_set, cv_set}, {v[4:0], v[9:5]});
        end
        $display("settings test done");
        apb(1'b1, chg_pkg::ADDR_CTRL, 32'h08);
        // software side: enable first, hold a higher setting, only then go low
        apb(1'b1, chg_pkg::ADDR_CC, 32'(CC_HIGH));
        repeat (HOLD_T) @(posedge mclk);
        apb(1'b1, chg_pkg::ADDR_CC, 32'(CC_LOW));
        wait_state(chg_pkg::CHG_DONE);
        chk(rdat, stat_exp(1'b1, chg_pkg::CHG_DONE));
        apb(1'b0, chg_pkg::ADDR_GEN_STAT, 32'h0);
        chk(rdat & 32'h30, 32'h30);
        sup_bad <= 1'b1;
        wait_state(chg_pkg::CHG_STANDBY);
        apb(1'b0, chg_pkg::ADDR_GEN_STAT, 32'h0);
        chk(rdat & 32'h08, 32'h08);
        sup_bad <= 1'b0;
        wait_state(chg_pkg::CHG_DONE);
        drain <= 1'b1;
        wait_state(chg_pkg::CHG_CC);
        drain <= 1'b0;
        wait_state(chg_pkg::CHG_DONE);
        inhibit <= 1'b1;
        wait_state(chg_pkg::CHG_OFF);
        inhibit <= 1'b0;
        wait_state(chg_pkg::CHG_DONE);
        hot <= 1'b1;
        wait_state(chg_pkg::CHG_OFF);
        hot <= 1'b0;
        apb(1'b1, chg_pkg::ADDR_CTRL, 32'h00);
        wait_state(chg_pkg::CHG_OFF);
        chk(rdat, stat_exp(1'b0, chg_pkg::CHG_OFF));
        $display("charger test done");
        apb(1'b1, chg_pkg::ADDR_CTRL, 32'h8A);
        repeat (2) @(posedge mclk);
        chk(32'(drive.health_check_on), 32'h1);
        rail_low <= 1'b1;
        pulse_chk();
        chk({alert_out_n, alert_oe_n, drive.health_check_on, drive.charger_on, drive.boost_regulate}, 32'h1);
        rail_low <= 1'b0;
        repeat (20) @(posedge mclk);
        rail_low <= 1'b1;
        pulse_chk();
        chk({cc_set, cv_set}, {CC_LOW, v[9:5]});
        $display("boost test done");
        bias_ok <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(32'(drive[4:2]), 32'h0);
        $display("bias test done");
        finish_test();
    end
endmodule : backup_charger_boost_control_tb_top
